// file: core/mcar_arbiter.sv
// Fixed-priority arbiter with programmable ranks.
`timescale 1ns/1ps
module mcar_arbiter
  import mcar_pkg::*;
#(
  parameter int NM = 4,
  parameter int PW = 3,
  parameter int IW = 2
) (
  // Requests and ranks
  input  wire logic [NM-1:0]         req,
  input  wire logic [NM-1:0][PW-1:0] prio,
  // Winner
  output logic                       winValid,
  output logic      [IW-1:0]         winIdx
);

  logic [PW-1:0] best;

  // --------------------------------------------------------------------
  // Highest rank wins; the downward scan lets the lower index take ties.
  // --------------------------------------------------------------------
  always_comb begin
    winValid = 1'b0;
    winIdx   = '0;
    best     = '0;
    for (int i = NM - 1; i >= 0; i--) begin
      if (req[i] && (!winValid || prio[i] >= best)) begin
        winValid = 1'b1;
        winIdx   = IW'(i);
        best     = prio[i];
      end
    end
  end

endmodule : mcar_arbiter

// file: core/mcar_regs.sv
// Memory controller remap, abort capture and arbitration registers.
//
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/1ps
`include "mcar_defs.svh"
module mcar_regs
  import mcar_pkg::*;
#(
  parameter int NM = 4,
  parameter int PW = 3,
  parameter int IW = 2
) (
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  resetn,
  // Avalon-MM register slave
  input  wire logic [7:0]            avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output logic      [31:0]           avs_readdata,
  output logic                       avs_waitrequest,
  // Master requests
  input  wire logic [NM-1:0]         mstReq,
  input  wire logic [NM-1:0][31:0]   mstAddr,
  input  wire logic [NM-1:0][1:0]    mstSize,
  input  wire logic [NM-1:0][1:0]    mstType,
  // Granted access
  output logic                       busGrantValid,
  output logic      [IW-1:0]         busGrantMaster,
  output logic      [31:0]           busAddr,
  output logic      [1:0]            busSize,
  output logic      [1:0]            busType,
  // Abort broadcast and state
  output logic                       abortPulse,
  output logic      [IW-1:0]         abortMaster,
  output logic                       remapActive,
  output logic                       irq
);

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  logic [NM-1:0][PW-1:0] prio;
  logic [NM-1:0][PW-1:0] next_prio;
  logic                  next_remapActive;
  logic                  undFlag;
  logic                  next_undFlag;
  logic                  misFlag;
  logic                  next_misFlag;
  logic [1:0]            abtSize;
  logic [1:0]            next_abtSize;
  logic [1:0]            abtType;
  logic [1:0]            next_abtType;
  logic [NM-1:0]         lastSrc;
  logic [NM-1:0]         next_lastSrc;
  logic [NM-1:0]         sticky;
  logic [NM-1:0]         next_sticky;
  logic                  sinceRead;
  logic                  next_sinceRead;
  mcar_word_t            abtAddr;
  mcar_word_t            next_abtAddr;
  logic [NM-1:0]         irqStat;
  logic [NM-1:0]         next_irqStat;
  logic [NM-1:0]         irqMask;
  logic [NM-1:0]         next_irqMask;
  logic                  next_irq;
  logic [31:0]           next_readdata;
  logic                  next_waitrequest;
  logic                  next_grantValid;
  logic [IW-1:0]         next_grantMaster;
  logic [31:0]           next_busAddr;
  logic [1:0]            next_busSize;
  logic [1:0]            next_busType;
  logic                  next_abortPulse;
  logic [IW-1:0]         next_abortMaster;

  logic                  winValid;
  logic [IW-1:0]         winIdx;
  logic [31:0]           selAddr;
  logic [1:0]            selSize;
  logic [1:0]            selType;
  logic                  isUndef;
  logic                  isMis;
  logic                  doAbort;
  logic [NM-1:0]         winOneHot;
  logic                  wrDone;
  logic                  rdDone;
  logic [31:0]           wmask;
  logic [31:0]           wval;

  // --------------------------------------------------------------------
  // Arbitration
  // --------------------------------------------------------------------
  mcar_arbiter #(
    .NM (NM),
    .PW (PW),
    .IW (IW)
  ) uArb (
    .req      (mstReq),
    .prio     (prio),
    .winValid (winValid),
    .winIdx   (winIdx)
  );

  // --------------------------------------------------------------------
  // Access checks
  // --------------------------------------------------------------------
  always_comb begin
    selAddr   = mstAddr[winIdx];
    selSize   = mstSize[winIdx];
    selType   = mstType[winIdx];
    winOneHot = '0;
    winOneHot[winIdx] = 1'b1;
    isUndef = (selAddr[`MCAR_INT_AREA_MSB:`MCAR_INT_AREA_LSB] == 4'h0)
      && (selAddr[`MCAR_UNDEF_MSB:`MCAR_UNDEF_LSB] != 6'h00);
    isMis = 1'b0;
    if (selType != MCAR_TY_FETCH) begin
      if (selSize == MCAR_SZ_WORD) begin
        isMis = (selAddr[1:0] != 2'h0);
      end else if (selSize == MCAR_SZ_HALF) begin
        isMis = selAddr[0];
      end
    end
    doAbort = winValid && (isUndef || isMis);
  end

  // --------------------------------------------------------------------
  // Granted access and abort broadcast
  // --------------------------------------------------------------------
  always_comb begin
    next_grantValid  = winValid && !doAbort;
    next_grantMaster = winIdx;
    next_busSize     = selSize;
    next_busType     = selType;
    next_busAddr     = selAddr;
    if (remapActive && selAddr[`MCAR_AREA0_MSB:`MCAR_AREA0_LSB] == 12'h000)
    begin
      next_busAddr = selAddr | `MCAR_SRAM_BASE;
    end
    next_abortPulse  = doAbort;
    next_abortMaster = winIdx;
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      busGrantValid  <= 1'b0;
      busGrantMaster <= '0;
      busAddr        <= 32'h0000_0000;
      busSize        <= 2'h0;
      busType        <= 2'h0;
      abortPulse     <= 1'b0;
      abortMaster    <= '0;
    end else begin
      busGrantValid  <= next_grantValid;
      busGrantMaster <= next_grantMaster;
      busAddr        <= next_busAddr;
      busSize        <= next_busSize;
      busType        <= next_busType;
      abortPulse     <= next_abortPulse;
      abortMaster    <= next_abortMaster;
    end
  end

  // --------------------------------------------------------------------
  // Bus handshake and read data
  // --------------------------------------------------------------------
  always_comb begin
    next_waitrequest = !((avs_read || avs_write) && avs_waitrequest);
    wrDone = avs_write && !avs_waitrequest;
    rdDone = avs_read && !avs_waitrequest;
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{avs_byteenable[b]}};
    end
    wval = avs_writedata & wmask;
    next_readdata = 32'h0000_0000;
    if (avs_read && avs_waitrequest) begin
      case (avs_address)
        `MCAR_OFF_STATUS: begin
          next_readdata[`MCAR_UND_BIT] = undFlag;
          next_readdata[`MCAR_MIS_BIT] = misFlag;
          next_readdata[`MCAR_SIZE_LSB +: 2] = abtSize;
          next_readdata[`MCAR_TYPE_LSB +: 2] = abtType;
          next_readdata[`MCAR_LAST_LSB +: NM] = lastSrc;
          next_readdata[`MCAR_STICKY_LSB +: NM] = sticky;
        end
        `MCAR_OFF_ABTADDR: begin
          next_readdata = abtAddr;
        end
        `MCAR_OFF_PRIO: begin
          for (int i = 0; i < NM; i++) begin
            next_readdata[i*`MCAR_PRIO_STRIDE +: PW] = prio[i];
          end
        end
        `MCAR_OFF_IRQSTAT: begin
          next_readdata[NM-1:0] = irqStat;
        end
        `MCAR_OFF_IRQMASK: begin
          next_readdata[NM-1:0] = irqMask;
        end
        default: begin
          next_readdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= next_waitrequest;
      avs_readdata    <= next_readdata;
    end
  end

  // --------------------------------------------------------------------
  // Remap toggle and priority register
  // --------------------------------------------------------------------
  always_comb begin
    next_remapActive = remapActive;
    next_prio        = prio;
    if (wrDone && avs_address == `MCAR_OFF_REMAP
        && wval[`MCAR_REMAP_BIT]) begin
      next_remapActive = !remapActive;
    end
    if (wrDone && avs_address == `MCAR_OFF_PRIO) begin
      for (int i = 0; i < NM; i++) begin
        if (avs_byteenable[(i*`MCAR_PRIO_STRIDE)/8]) begin
          next_prio[i] = avs_writedata[i*`MCAR_PRIO_STRIDE +: PW];
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      remapActive <= 1'b0;
      for (int i = 0; i < NM; i++) begin
        prio[i] <= PW'(`MCAR_PRIO_RST >> (i * `MCAR_PRIO_STRIDE));
      end
    end else begin
      remapActive <= next_remapActive;
      prio        <= next_prio;
    end
  end

  // --------------------------------------------------------------------
  // Abort capture
  // --------------------------------------------------------------------
  always_comb begin
    next_undFlag   = undFlag;
    next_misFlag   = misFlag;
    next_abtSize   = abtSize;
    next_abtType   = abtType;
    next_lastSrc   = lastSrc;
    next_abtAddr   = abtAddr;
    next_sinceRead = sinceRead;
    next_sticky    = sticky;
    if (rdDone && avs_address == `MCAR_OFF_STATUS) begin
      next_sticky    = sticky & ~avs_readdata[`MCAR_STICKY_LSB +: NM];
      next_sinceRead = 1'b0;
    end
    if (doAbort) begin
      next_undFlag   = isUndef;
      next_misFlag   = isMis;
      next_abtSize   = selSize;
      next_abtType   = selType;
      next_lastSrc   = winOneHot;
      next_abtAddr   = selAddr;
      next_sinceRead = 1'b1;
      if (sinceRead) begin
        next_sticky = next_sticky | lastSrc;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      undFlag   <= 1'b0;
      misFlag   <= 1'b0;
      abtSize   <= 2'h0;
      abtType   <= 2'h0;
      lastSrc   <= '0;
      sticky    <= '0;
      sinceRead <= 1'b0;
      abtAddr   <= `MCAR_ABTADDR_RST;
    end else begin
      undFlag   <= next_undFlag;
      misFlag   <= next_misFlag;
      abtSize   <= next_abtSize;
      abtType   <= next_abtType;
      lastSrc   <= next_lastSrc;
      sticky    <= next_sticky;
      sinceRead <= next_sinceRead;
      abtAddr   <= next_abtAddr;
    end
  end

  // --------------------------------------------------------------------
  // Interrupt status, mask and output
  // --------------------------------------------------------------------
  always_comb begin
    next_irqStat = irqStat;
    next_irqMask = irqMask;
    if (wrDone && avs_address == `MCAR_OFF_IRQSTAT) begin
      next_irqStat = irqStat & ~wval[NM-1:0];
    end
    if (wrDone && avs_address == `MCAR_OFF_IRQMASK && avs_byteenable[0]) begin
      next_irqMask = avs_writedata[NM-1:0];
    end
    if (doAbort) begin
      next_irqStat = next_irqStat | winOneHot;
    end
    next_irq = |(next_irqStat & next_irqMask);
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      irqStat <= `MCAR_IRQ_RST;
      irqMask <= `MCAR_IRQ_RST;
      irq     <= 1'b0;
    end else begin
      irqStat <= next_irqStat;
      irqMask <= next_irqMask;
      irq     <= next_irq;
    end
  end

endmodule : mcar_regs

// file: shared/mcar_defs.svh
// Offsets, field positions, reset values and decode limits of the block.
`ifndef MCAR_DEFS_SVH
`define MCAR_DEFS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define MCAR_OFF_REMAP    8'h00
`define MCAR_OFF_STATUS   8'h04
`define MCAR_OFF_ABTADDR  8'h08
`define MCAR_OFF_PRIO     8'h0C
`define MCAR_OFF_IRQSTAT  8'h80
`define MCAR_OFF_IRQMASK  8'h84

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define MCAR_REMAP_BIT    0
`define MCAR_UND_BIT      0
`define MCAR_MIS_BIT      1
`define MCAR_SIZE_LSB     8
`define MCAR_TYPE_LSB     10
`define MCAR_LAST_LSB     16
`define MCAR_STICKY_LSB   24
`define MCAR_PRIO_STRIDE  4

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define MCAR_STATUS_RST   32'h0000_0000
`define MCAR_ABTADDR_RST  32'h0000_0000
`define MCAR_PRIO_RST     32'h0000_3210
`define MCAR_IRQ_RST      4'h0

// ----------------------------------------------------------------------
// Address decode
// ----------------------------------------------------------------------
`define MCAR_INT_AREA_MSB 31
`define MCAR_INT_AREA_LSB 28
`define MCAR_UNDEF_MSB    27
`define MCAR_UNDEF_LSB    22
`define MCAR_AREA0_MSB    31
`define MCAR_AREA0_LSB    20
`define MCAR_SRAM_BASE    32'h0020_0000

`endif

// file: shared/mcar_pkg.sv
// Types shared by the abort and remap register block.
package mcar_pkg;

  // --------------------------------------------------------------------
  // Access size and kind encodings
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    MCAR_SZ_BYTE = 2'b00,
    MCAR_SZ_HALF = 2'b01,
    MCAR_SZ_WORD = 2'b10,
    MCAR_SZ_RSVD = 2'b11
  } mcar_size_e;

  typedef enum logic [1:0] {
    MCAR_TY_READ  = 2'b00,
    MCAR_TY_WRITE = 2'b01,
    MCAR_TY_FETCH = 2'b10,
    MCAR_TY_RSVD  = 2'b11
  } mcar_type_e;

  typedef logic [31:0] mcar_word_t;

endpackage : mcar_pkg

// file: sim/mcar_master_model.sv
// Model of the four bus masters.
`timescale 1ns/1ps
module mcar_master_model
  import mcar_pkg::*;
(
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             resetn,
  // Commands from the bench
  input  wire logic             cmdValid,
  input  wire logic [3:0]       cmdMask,
  input  wire logic [31:0]      cmdAddr,
  input  wire logic [3:0]       cmdAttr,
  output logic                  idle,
  // Outcome from the block
  input  wire logic             busGrantValid,
  input  wire logic [1:0]       busGrantMaster,
  input  wire logic             abortPulse,
  input  wire logic [1:0]       abortMaster,
  // Requests
  output logic      [3:0]       mstReq,
  output logic      [3:0][31:0] mstAddr,
  output logic      [3:0][1:0]  mstSize,
  output logic      [3:0][1:0]  mstType
);
  logic [3:0]  pend, hold, attr, next_pend, next_attr;
  logic [31:0] addr, next_addr;
  assign mstReq = pend & ~hold;
  assign idle   = pend == 4'h0;
  // A master rests one cycle after asking, then asks again if unserved.
  always_comb begin
    next_pend = cmdValid ? cmdMask : pend;
    next_addr = cmdValid ? cmdAddr : addr;
    next_attr = cmdValid ? cmdAttr : attr;
    if (busGrantValid) next_pend[busGrantMaster] = 1'b0;
    if (abortPulse) next_pend[abortMaster] = 1'b0;
    for (int m = 0; m < 4; m++) begin
      mstAddr[m] = mstReq[m] ? addr : ~addr;
      mstSize[m] = mstReq[m] ? attr[3:2] : ~attr[3:2];
      mstType[m] = mstReq[m] ? attr[1:0] : ~attr[1:0];
    end
  end
  always_ff @(posedge mclk) begin
    pend <= resetn ? next_pend : 4'h0;
    hold <= resetn ? mstReq : 4'h0;
    addr <= next_addr;
    attr <= next_attr;
  end
endmodule : mcar_master_model

// file: sim/mcar_regs_chk.sv
// Checker of the register block ports.
`timescale 1ns/1ps
module mcar_regs_chk
  import mcar_pkg::*;
#(
  parameter int NM = 4,
  parameter int PW = 3,
  parameter int IW = 2
) (
  // Clock and reset
  input wire logic                mclk,
  input wire logic                resetn,
  // Register bus
  input wire logic [7:0]          avs_address,
  input wire logic                avs_read,
  input wire logic                avs_write,
  input wire logic [31:0]         avs_writedata,
  input wire logic [3:0]          avs_byteenable,
  input wire logic [31:0]         avs_readdata,
  input wire logic                avs_waitrequest,
  // Masters and outcomes
  input wire logic [NM-1:0]       mstReq,
  input wire logic [NM-1:0][31:0] mstAddr,
  input wire logic [NM-1:0][1:0]  mstSize,
  input wire logic [NM-1:0][1:0]  mstType,
  input wire logic                busGrantValid,
  input wire logic [IW-1:0]       busGrantMaster,
  input wire logic [31:0]         busAddr,
  input wire logic                abortPulse,
  input wire logic [IW-1:0]       abortMaster,
  input wire logic                remapActive
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  logic rdEnd;
  logic flip;
  assign rdEnd = avs_read && !avs_waitrequest;
  assign flip  = avs_write && !avs_waitrequest && avs_address == 8'h00
                 && avs_writedata[0] && avs_byteenable[0];
  a_wait_one: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("No answer after one wait cycle.");
  a_remap_flip: assert property (
    flip |=> remapActive != $past(remapActive))
    else $error("Remap did not toggle.");
  a_remap_keep: assert property (
    !flip |=> $stable(remapActive))
    else $error("Remap changed without a command.");
  a_undef_abort: assert property (
    mstReq == 4'b0001 && mstAddr[0][31:28] == 4'h0
    && mstAddr[0][27:22] != 6'h00
    |=> abortPulse && abortMaster == 2'd0 && !busGrantValid)
    else $error("Undefined access not aborted.");
  a_misalign: assert property (
    mstReq == 4'b1000 && mstType[3] != 2'b10 && mstSize[3] == 2'b10
    && mstAddr[3][1:0] != 2'b00 |=> abortPulse && abortMaster == 2'd3)
    else $error("Misaligned word not aborted.");
  a_fetch_free: assert property (
    mstReq == 4'b0010 && mstType[1] == 2'b10 && mstAddr[1][31:22] == 10'h0
    |=> busGrantValid && busGrantMaster == 2'd1 && !abortPulse)
    else $error("Fetch was refused.");
  a_remap_addr: assert property (
    busGrantValid && $past(remapActive) && $past(mstReq) == 4'b0001
    && $past(mstAddr[0]) < 32'h0010_0000
    |-> busAddr == ($past(mstAddr[0]) | 32'h0020_0000))
    else $error("Remapped address wrong.");
  a_rsvd_zero: assert property (
    rdEnd && (avs_address == 8'h00 || avs_address inside {[8'h10:8'h5C]})
    |-> avs_readdata == 32'h0)
    else $error("Reserved read not zero.");
  a_status_bits: assert property (
    rdEnd && avs_address == 8'h04 |-> $onehot0(avs_readdata[19:16])
    && (avs_readdata & 32'hF0F0_F0FC) == 32'h0)
    else $error("Status bits malformed.");
  a_prio_bits: assert property (
    rdEnd && avs_address == 8'h0C |-> (avs_readdata & 32'hFFFF_8888) == 0)
    else $error("Priority reserved bits set.");
  c_abort3: cover property (abortPulse && abortMaster == 2'd3);
  c_remap: cover property (busGrantValid && remapActive);
  c_sticky: cover property (rdEnd && avs_address == 8'h04
                            && avs_readdata[25]);
endmodule : mcar_regs_chk

bind mcar_regs mcar_regs_chk #(.NM(NM), .PW(PW), .IW(IW)) mcar_regs_chk_i (
  .mclk(mclk), .resetn(resetn), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .mstReq(mstReq), .mstAddr(mstAddr),
  .mstSize(mstSize), .mstType(mstType), .busGrantValid(busGrantValid),
  .busGrantMaster(busGrantMaster), .busAddr(busAddr),
  .abortPulse(abortPulse), .abortMaster(abortMaster),
  .remapActive(remapActive)
);

// file: sim/tb_mcar_regs.sv
// Self-checking bench of the register block.
`timescale 1ns/1ps
module tb_mcar_regs import mcar_pkg::*;;
  logic             mclk = 1'b0, resetn = 1'b0, cmdValid = 1'b0;
  logic             avs_read = 1'b0, avs_write = 1'b0;
  logic [7:0]       avs_address = 8'h00;
  logic [31:0]      avs_writedata = 32'h0, cmdAddr = 32'h0;
  logic [3:0]       avs_byteenable = 4'hF, cmdMask = 4'h0, cmdAttr = 4'h0;
  logic [31:0]      avs_readdata, busAddr, a, u;
  logic [3:0]       mstReq;
  logic [3:0][31:0] mstAddr;
  logic [3:0][1:0]  mstSize, mstType;
  logic             avs_waitrequest, busGrantValid, abortPulse;
  logic             remapActive, irq, idle;
  logic [1:0]       busGrantMaster, abortMaster, busSize, busType;
  logic [31:0]      expRd[$];
  logic [38:0]      expEv[$];
  int               bad_count = 0, cmp_count = 0, cyc = 0;
  always #4 mclk = ~mclk;
  mcar_regs mcar_regs_i (.mclk(mclk), .resetn(resetn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .mstReq(mstReq), .mstAddr(mstAddr), .mstSize(mstSize),
    .mstType(mstType), .busGrantValid(busGrantValid),
    .busGrantMaster(busGrantMaster), .busAddr(busAddr), .busSize(busSize),
    .busType(busType), .abortPulse(abortPulse), .abortMaster(abortMaster),
    .remapActive(remapActive), .irq(irq));
  mcar_master_model mcar_master_model_i (.mclk(mclk), .resetn(resetn),
    .cmdValid(cmdValid), .cmdMask(cmdMask), .cmdAddr(cmdAddr),
    .cmdAttr(cmdAttr), .idle(idle), .busGrantValid(busGrantValid),
    .busGrantMaster(busGrantMaster), .abortPulse(abortPulse),
    .abortMaster(abortMaster), .mstReq(mstReq), .mstAddr(mstAddr),
    .mstSize(mstSize), .mstType(mstType));
  task automatic report_and_stop();
    if (bad_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [38:0] s, input logic [38:0] e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("Error %0t: saw %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] ad,
                     input logic [31:0] d, input logic [3:0] be);
    @(posedge mclk);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= ad;
    avs_writedata <= d;
    avs_byteenable <= be;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic rd(input logic [7:0] ad, input logic [31:0] e);
    expRd.push_back(e);
    bus(1'b0, ad, 32'h0, 4'hF);
  endtask : rd
  function automatic void ev(input logic ab, input logic [1:0] m,
                             input logic [3:0] at, input logic [31:0] ad);
    expEv.push_back(ab ? {1'b1, m, 36'h0} : {1'b0, m, at, ad});
  endfunction : ev
  task automatic go(input logic [3:0] mk, input logic [31:0] ad,
                    input logic [3:0] at);
    @(posedge mclk);
    cmdValid <= 1'b1;
    cmdMask <= mk;
    cmdAddr <= ad;
    cmdAttr <= at;
    @(posedge mclk);
    cmdValid <= 1'b0;
    do @(posedge mclk); while (idle !== 1'b1);
  endtask : go
  task automatic prio(input logic [31:0] d, input logic [3:0] be,
                      input logic [31:0] e);
    bus(1'b1, 8'h0C, d, be);
    rd(8'h0C, e);
    for (int r = 7; r >= 0; r--)
      for (int m = 0; m < 4; m++)
        if (e[4 * m +: 3] == r) ev(1'b0, 2'(m), 4'b1001, a);
    go(4'hF, a, 4'b1001);
  endtask : prio
  task automatic irqchk(input logic e);
    repeat (2) @(posedge mclk);
    chk(39'(irq), 39'(e));
  endtask : irqchk
  always @(posedge mclk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
      chk(39'(avs_readdata),
          39'(expRd.size() ? expRd.pop_front() : 'x));
    if (busGrantValid === 1'b1 || abortPulse === 1'b1)
      chk(abortPulse ? {1'b1, abortMaster, 36'h0}
                     : {1'b0, busGrantMaster, busSize, busType, busAddr},
          expEv.size() ? expEv.pop_front() : 'x);
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end
  initial begin
    void'($urandom(32'hBA2DA7C6));
    a = $urandom & 32'h000F_FFFC;
    u = {4'h0, 6'h01 + 6'($urandom % 63), 22'($urandom)};
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    for (int i = 0; i < 36; i++)
      rd(8'(4 * i), (i == 3) ? 32'h3210 : 32'h0);
    for (int i = 0; i < 3; i++) begin
      wr_remap(i);
    end
    prio(32'h0, 4'hF, 32'h0);
    prio(32'hFFFF_FFFF, 4'hF, 32'h7777);
    prio(32'h7531, 4'hF, 32'h7531);
    prio(32'hFFFF_FFFF, 4'h1, 32'h7577);
    bus(1'b1, 8'h84, 32'hF, 4'hF);
    ev(1'b1, 2'd0, 4'h0, 32'h0);
    go(4'h1, 32'h0040_0000, 4'b0000);
    rd(8'h04, 32'h0001_0001);
    rd(8'h08, 32'h0040_0000);
    irqchk(1'b1);
    bus(1'b1, 8'h80, 32'h1, 4'hF);
    irqchk(1'b0);
    bus(1'b1, 8'h84, 32'h0, 4'hF);
    ev(1'b1, 2'd3, 4'h0, 32'h0);
    go(4'h8, a | 32'h3, 4'b1001);
    rd(8'h04, 32'h0008_0602);
    irqchk(1'b0);
    bus(1'b1, 8'h84, 32'h8, 4'hF);
    irqchk(1'b1);
    bus(1'b1, 8'h80, 32'h8, 4'hF);
    irqchk(1'b0);
    ev(1'b1, 2'd2, 4'h0, 32'h0);
    go(4'h4, a | 32'h1, 4'b0100);
    rd(8'h04, 32'h0004_0102);
    ev(1'b0, 2'd1, 4'b1010, a | 32'h3);
    go(4'h2, a | 32'h3, 4'b1010);
    ev(1'b0, 2'd0, 4'b0000, a | 32'h1);
    go(4'h1, a | 32'h1, 4'b0000);
    ev(1'b1, 2'd1, 4'h0, 32'h0);
    go(4'h2, 32'h0080_0000, 4'b0000);
    ev(1'b1, 2'd2, 4'h0, 32'h0);
    go(4'h4, u, 4'b0000);
    rd(8'h04, 32'h0204_0001);
    rd(8'h04, 32'h0004_0001);
    rd(8'h08, u);
    report_and_stop();
  end
  task automatic wr_remap(input int i);
    bus(1'b1, 8'h00, 32'(i != 0), 4'hF);
    ev(1'b0, 2'd0, 4'b1000, (i == 1) ? (a | 32'h0020_0000) : a);
    go(4'h1, a, 4'b1000);
    chk(39'(remapActive), 39'(i == 1));
  endtask : wr_remap
endmodule : tb_mcar_regs
